// >>> rtl/txcd_pkg.sv
// Constants and types shared by the transmit command word decoder
package txcd_pkg;

  // Widths
  localparam int LEN_W  = 11;
  localparam int WCNT_W = 10;
  localparam int SUM_W  = 16;

  // First command word fields
  localparam int CMDA_SIZE_LSB  = 0;
  localparam int CMDA_SIZE_MSB  = 10;
  localparam int CMDA_LAST_BIT  = 12;
  localparam int CMDA_FIRST_BIT = 13;
  localparam int CMDA_OFS_LSB   = 16;
  localparam int CMDA_OFS_MSB   = 20;
  localparam int CMDA_ALN_LSB   = 24;
  localparam int CMDA_ALN_MSB   = 25;

  // Second command word fields
  localparam int CMDB_LEN_LSB   = 0;
  localparam int CMDB_LEN_MSB   = 10;
  localparam int CMDB_NOPAD_BIT = 12;
  localparam int CMDB_NOCRC_BIT = 13;
  localparam int CMDB_TAG_LSB   = 16;
  localparam int CMDB_TAG_MSB   = 31;

  // End alignment codes
  localparam logic [1:0] ALIGN_4  = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;

  // Bytes in one double-word
  localparam logic [2:0] DW_BYTES = 3'h4;

  // Reset values
  localparam logic [SUM_W-1:0] SUM_RESET = 16'h0000;
  localparam logic [15:0]      TAG_RESET = 16'h0000;

  typedef enum logic [2:0] {
    ST_CMD_A = 3'h1,
    ST_CMD_B = 3'h2,
    ST_BODY  = 3'h4
  } txcd_state_t;

endpackage : txcd_pkg

// >>> rtl/txcd_len_if.sv
// Segment length handover between the decoder and the length checker
`timescale 1ns/1ps
interface txcd_len_if;
  logic                       seg_done;
  logic                       seg_first;
  logic                       seg_last;
  logic [txcd_pkg::LEN_W-1:0] seg_bytes;
  logic [txcd_pkg::LEN_W-1:0] pkt_len;
  logic                       mismatch;

  modport ctrl (output seg_done, output seg_first, output seg_last, output seg_bytes, output pkt_len,
                input mismatch);
  modport chk  (input seg_done, input seg_first, input seg_last, input seg_bytes, input pkt_len,
                output mismatch);
endinterface : txcd_len_if

// >>> rtl/txcd_cmd_a_decode.sv
// Word layout of one buffer computed from its first command word
`timescale 1ns/1ps
module txcd_cmd_a_decode (
  // Command word
  input  wire logic [31:0]                cmd_in,
  // Buffer layout in double-words
  output logic      [2:0]                 skip_words_out,
  output logic      [txcd_pkg::WCNT_W-1:0] end_words_out,
  output logic      [txcd_pkg::WCNT_W-1:0] total_words_out
);
  logic [4:0]                 ofs;
  logic [txcd_pkg::LEN_W-1:0] size;
  logic [1:0]                 aln;
  logic [11:0]                span;
  logic [11:0]                amask;
  logic [11:0]                rounded;
  logic [11:0]                data_span;

  always_comb begin
    ofs  = cmd_in[txcd_pkg::CMDA_OFS_MSB:txcd_pkg::CMDA_OFS_LSB];
    size = cmd_in[txcd_pkg::CMDA_SIZE_MSB:txcd_pkg::CMDA_SIZE_LSB];
    aln  = cmd_in[txcd_pkg::CMDA_ALN_MSB:txcd_pkg::CMDA_ALN_LSB];
    span = {7'h00, ofs} + {1'b0, size};
    case (aln)
      txcd_pkg::ALIGN_16: amask = 12'h00F;
      txcd_pkg::ALIGN_32: amask = 12'h01F;
      default:            amask = 12'h003;
    endcase
    rounded   = (span + amask) & ~amask;
    data_span = {10'h000, ofs[1:0]} + {1'b0, size} + 12'h003;
    skip_words_out  = ofs[4:2];
    total_words_out = rounded[11:2];
    end_words_out   = data_span[11:2] + {7'h00, ofs[4:2]};
  end
endmodule : txcd_cmd_a_decode

// >>> rtl/txcd_len_check.sv
// Running byte total across a packet's segments and length comparison
`timescale 1ns/1ps
module txcd_len_check (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Segment reports
  txcd_len_if.chk   len_if
);
  logic [txcd_pkg::SUM_W-1:0] sum_q;
  logic [txcd_pkg::SUM_W-1:0] sum_d;
  logic [txcd_pkg::SUM_W-1:0] base;
  logic [txcd_pkg::SUM_W-1:0] sum_new;

  always_comb begin
    base    = len_if.seg_first ? txcd_pkg::SUM_RESET : sum_q;
    sum_new = base + {5'h00, len_if.seg_bytes};
    len_if.mismatch = len_if.seg_done && len_if.seg_last &&
                      (sum_new != {5'h00, len_if.pkt_len});
    sum_d = sum_q;
    if (len_if.seg_done) begin
      sum_d = len_if.seg_last ? txcd_pkg::SUM_RESET : sum_new;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sum_q <= txcd_pkg::SUM_RESET;
    end else begin
      sum_q <= sum_d;
    end
  end
endmodule : txcd_len_check

// >>> rtl/txcd_decoder.sv
// Transmit command word decoder: parses buffers, strips offsets and padding, checks lengths
//
// Functional notes
// - first-segment bit opens a new packet
// - last-segment bit closes the current packet
// - first word low bits give buffer bytes
// - size and alignment locate trailing pad words
// - running segment sum compared to packet length
// - packet tag copied into transmit status
// - tag passed through without any checking
// - CRC-disable bit stops FCS append
// - pad-disable bit stops short-frame padding
// - pad disabled forces FCS append anyway
// - second word low bits give packet length
// - length mismatch raises transmit error flag
// - data follows both command words
// - end alignment is 4, 16 or 32
// - whole-word start offset words are skipped
`timescale 1ns/1ps
module txcd_decoder (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Transmit FIFO word stream from the host
  input  wire logic        in_valid_in,
  input  wire logic [31:0] in_data_in,
  output logic             in_ready_out,
  // Data stream towards the transmitter
  output logic             out_valid_out,
  input  wire logic        out_ready_in,
  output logic [31:0]      out_data_out,
  output logic [1:0]       out_first_byte_out,
  output logic [2:0]       out_byte_count_out,
  output logic             out_sop_out,
  output logic             out_eop_out,
  output logic             out_fcs_append_out,
  output logic             out_pad_enable_out,
  // Transmit status tag
  output logic             status_valid_out,
  output logic [15:0]      status_tag_out,
  output logic             status_len_error_out,
  // Error flag
  input  wire logic        transmit_error_clear_in,
  output logic             transmit_error_flag_out
);

  // Parser state
  txcd_pkg::txcd_state_t              state_q;
  txcd_pkg::txcd_state_t              state_d;
  logic [txcd_pkg::WCNT_W-1:0]        word_q;
  logic [txcd_pkg::WCNT_W-1:0]        word_d;

  // Current buffer from the first command word
  logic                               a_first_q;
  logic                               a_first_d;
  logic                               a_last_q;
  logic                               a_last_d;
  logic [txcd_pkg::LEN_W-1:0]         a_size_q;
  logic [txcd_pkg::LEN_W-1:0]         a_size_d;
  logic [1:0]                         a_lead_q;
  logic [1:0]                         a_lead_d;
  logic [2:0]                         skip_q;
  logic [2:0]                         skip_d;
  logic [txcd_pkg::WCNT_W-1:0]        end_q;
  logic [txcd_pkg::WCNT_W-1:0]        end_d;
  logic [txcd_pkg::WCNT_W-1:0]        total_q;
  logic [txcd_pkg::WCNT_W-1:0]        total_d;
  logic [txcd_pkg::LEN_W-1:0]         rem_q;
  logic [txcd_pkg::LEN_W-1:0]         rem_d;

  // Packet controls from the second command word
  logic [15:0]                        tag_q;
  logic [15:0]                        tag_d;
  logic                               no_crc_q;
  logic                               no_crc_d;
  logic                               no_pad_q;
  logic                               no_pad_d;
  logic [txcd_pkg::LEN_W-1:0]         pkt_len_q;
  logic [txcd_pkg::LEN_W-1:0]         pkt_len_d;

  // Output registers
  logic                               out_valid_q;
  logic                               out_valid_d;
  logic [31:0]                        out_data_q;
  logic [31:0]                        out_data_d;
  logic [1:0]                         out_lead_q;
  logic [1:0]                         out_lead_d;
  logic [2:0]                         out_cnt_q;
  logic [2:0]                         out_cnt_d;
  logic                               out_sop_q;
  logic                               out_sop_d;
  logic                               out_eop_q;
  logic                               out_eop_d;
  logic                               out_fcs_q;
  logic                               out_fcs_d;
  logic                               out_pad_q;
  logic                               out_pad_d;
  logic                               stat_valid_q;
  logic                               stat_valid_d;
  logic [15:0]                        stat_tag_q;
  logic [15:0]                        stat_tag_d;
  logic                               stat_err_q;
  logic                               stat_err_d;
  logic                               txerr_q;
  logic                               txerr_d;

  // Combinational helpers
  logic                               accept;
  logic                               seg_done;
  logic [2:0]                         dec_skip;
  logic [txcd_pkg::WCNT_W-1:0]        dec_end;
  logic [txcd_pkg::WCNT_W-1:0]        dec_total;
  logic [1:0]                         lead;
  logic [2:0]                         room;
  logic [2:0]                         cnt;
  logic                               in_data_zone;
  logic [txcd_pkg::LEN_W-1:0]         len_field;

  txcd_len_if len_if ();

  txcd_cmd_a_decode u_cmd_a_decode (
    .cmd_in          (in_data_in),
    .skip_words_out  (dec_skip),
    .end_words_out   (dec_end),
    .total_words_out (dec_total)
  );

  txcd_len_check u_len_check (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .len_if   (len_if)
  );

  // A word is taken whenever the output register is free or draining
  assign in_ready_out = !out_valid_q || out_ready_in;
  assign accept       = in_valid_in && in_ready_out;
  assign len_field    = in_data_in[txcd_pkg::CMDB_LEN_MSB:txcd_pkg::CMDB_LEN_LSB];

  always_comb begin
    lead = (word_q == {7'h00, skip_q}) ? a_lead_q : 2'h0;
    room = txcd_pkg::DW_BYTES - {1'b0, lead};
    cnt  = (rem_q < {8'h00, room}) ? rem_q[2:0] : room;
    in_data_zone = (word_q >= {7'h00, skip_q}) && (word_q < end_q);
  end

  always_comb begin
    state_d      = state_q;
    word_d       = word_q;
    a_first_d    = a_first_q;
    a_last_d     = a_last_q;
    a_size_d     = a_size_q;
    a_lead_d     = a_lead_q;
    skip_d       = skip_q;
    end_d        = end_q;
    total_d      = total_q;
    rem_d        = rem_q;
    tag_d        = tag_q;
    no_crc_d     = no_crc_q;
    no_pad_d     = no_pad_q;
    pkt_len_d    = pkt_len_q;
    out_valid_d  = out_valid_q;
    out_data_d   = out_data_q;
    out_lead_d   = out_lead_q;
    out_cnt_d    = out_cnt_q;
    out_sop_d    = out_sop_q;
    out_eop_d    = out_eop_q;
    out_fcs_d    = out_fcs_q;
    out_pad_d    = out_pad_q;
    stat_valid_d = 1'b0;
    stat_tag_d   = stat_tag_q;
    stat_err_d   = stat_err_q;
    seg_done     = 1'b0;

    if (out_valid_q && out_ready_in) begin
      out_valid_d = 1'b0;
    end

    case (state_q)
      txcd_pkg::ST_CMD_A: begin
        if (accept) begin
          a_first_d = in_data_in[txcd_pkg::CMDA_FIRST_BIT];
          a_last_d  = in_data_in[txcd_pkg::CMDA_LAST_BIT];
          a_size_d  = in_data_in[txcd_pkg::CMDA_SIZE_MSB:txcd_pkg::CMDA_SIZE_LSB];
          a_lead_d  = in_data_in[txcd_pkg::CMDA_OFS_LSB+1:txcd_pkg::CMDA_OFS_LSB];
          skip_d    = dec_skip;
          end_d     = dec_end;
          total_d   = dec_total;
          state_d   = txcd_pkg::ST_CMD_B;
        end
      end
      txcd_pkg::ST_CMD_B: begin
        if (accept) begin
          if (a_first_q) begin
            tag_d    = in_data_in[txcd_pkg::CMDB_TAG_MSB:txcd_pkg::CMDB_TAG_LSB];
            no_crc_d = in_data_in[txcd_pkg::CMDB_NOCRC_BIT];
            no_pad_d = in_data_in[txcd_pkg::CMDB_NOPAD_BIT];
          end
          pkt_len_d = len_field;
          rem_d     = a_size_q;
          word_d    = {txcd_pkg::WCNT_W{1'b0}};
          if (total_q == {txcd_pkg::WCNT_W{1'b0}}) begin
            seg_done = 1'b1;
            state_d  = txcd_pkg::ST_CMD_A;
          end else begin
            state_d  = txcd_pkg::ST_BODY;
          end
        end
      end
      txcd_pkg::ST_BODY: begin
        if (accept) begin
          if (in_data_zone && (cnt != 3'h0)) begin
            out_valid_d = 1'b1;
            out_data_d  = in_data_in;
            out_lead_d  = lead;
            out_cnt_d   = cnt;
            out_sop_d   = a_first_q && (word_q == {7'h00, skip_q});
            out_eop_d   = a_last_q && (rem_q == {8'h00, cnt});
            out_fcs_d   = !no_crc_q || no_pad_q;
            out_pad_d   = !no_pad_q;
            rem_d       = rem_q - {8'h00, cnt};
          end
          if (word_q == total_q - 10'h001) begin
            seg_done = 1'b1;
            state_d  = txcd_pkg::ST_CMD_A;
          end else begin
            word_d   = word_q + 10'h001;
          end
        end
      end
      default: begin
        state_d = txcd_pkg::ST_CMD_A;
      end
    endcase

    if (seg_done && a_last_q) begin
      stat_valid_d = 1'b1;
      stat_tag_d   = tag_d;
      stat_err_d   = len_if.mismatch;
    end

    txerr_d = txerr_q;
    if (transmit_error_clear_in) begin
      txerr_d = 1'b0;
    end
    if (len_if.mismatch) begin
      txerr_d = 1'b1;
    end
  end

  // Length checker gets the closing word's packet length, even for empty buffers
  always_comb begin
    len_if.seg_done  = seg_done;
    len_if.seg_first = a_first_q;
    len_if.seg_last  = a_last_q;
    len_if.seg_bytes = a_size_q;
    len_if.pkt_len   = (state_q == txcd_pkg::ST_CMD_B) ? len_field : pkt_len_q;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q      <= txcd_pkg::ST_CMD_A;
      word_q       <= {txcd_pkg::WCNT_W{1'b0}};
      a_first_q    <= 1'b0;
      a_last_q     <= 1'b0;
      a_size_q     <= {txcd_pkg::LEN_W{1'b0}};
      a_lead_q     <= 2'h0;
      skip_q       <= 3'h0;
      end_q        <= {txcd_pkg::WCNT_W{1'b0}};
      total_q      <= {txcd_pkg::WCNT_W{1'b0}};
      rem_q        <= {txcd_pkg::LEN_W{1'b0}};
      tag_q        <= txcd_pkg::TAG_RESET;
      no_crc_q     <= 1'b0;
      no_pad_q     <= 1'b0;
      pkt_len_q    <= {txcd_pkg::LEN_W{1'b0}};
      out_valid_q  <= 1'b0;
      out_data_q   <= 32'h0000_0000;
      out_lead_q   <= 2'h0;
      out_cnt_q    <= 3'h0;
      out_sop_q    <= 1'b0;
      out_eop_q    <= 1'b0;
      out_fcs_q    <= 1'b0;
      out_pad_q    <= 1'b0;
      stat_valid_q <= 1'b0;
      stat_tag_q   <= txcd_pkg::TAG_RESET;
      stat_err_q   <= 1'b0;
      txerr_q      <= 1'b0;
    end else begin
      state_q      <= state_d;
      word_q       <= word_d;
      a_first_q    <= a_first_d;
      a_last_q     <= a_last_d;
      a_size_q     <= a_size_d;
      a_lead_q     <= a_lead_d;
      skip_q       <= skip_d;
      end_q        <= end_d;
      total_q      <= total_d;
      rem_q        <= rem_d;
      tag_q        <= tag_d;
      no_crc_q     <= no_crc_d;
      no_pad_q     <= no_pad_d;
      pkt_len_q    <= pkt_len_d;
      out_valid_q  <= out_valid_d;
      out_data_q   <= out_data_d;
      out_lead_q   <= out_lead_d;
      out_cnt_q    <= out_cnt_d;
      out_sop_q    <= out_sop_d;
      out_eop_q    <= out_eop_d;
      out_fcs_q    <= out_fcs_d;
      out_pad_q    <= out_pad_d;
      stat_valid_q <= stat_valid_d;
      stat_tag_q   <= stat_tag_d;
      stat_err_q   <= stat_err_d;
      txerr_q      <= txerr_d;
    end
  end

  assign out_valid_out           = out_valid_q;
  assign out_data_out            = out_data_q;
  assign out_first_byte_out      = out_lead_q;
  assign out_byte_count_out      = out_cnt_q;
  assign out_sop_out             = out_sop_q;
  assign out_eop_out             = out_eop_q;
  assign out_fcs_append_out      = out_fcs_q;
  assign out_pad_enable_out      = out_pad_q;
  assign status_valid_out        = stat_valid_q;
  assign status_tag_out          = stat_tag_q;
  assign status_len_error_out    = stat_err_q;
  assign transmit_error_flag_out = txerr_q;

endmodule : txcd_decoder

// >>> sim/txcd_decoder_chk.sv
// Port checks for the transmit command word decoder
`timescale 1ns/1ps
module txcd_decoder_chk (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  // Word stream
  input wire logic        in_ready_out,
  input wire logic        out_valid_out,
  input wire logic        out_ready_in,
  input wire logic [31:0] out_data_out,
  input wire logic [1:0]  out_first_byte_out,
  input wire logic [2:0]  out_byte_count_out,
  input wire logic        out_eop_out,
  input wire logic        out_fcs_append_out,
  input wire logic        out_pad_enable_out,
  // Status and flag
  input wire logic        status_valid_out,
  input wire logic [15:0] status_tag_out,
  input wire logic        status_len_error_out,
  input wire logic        transmit_error_clear_in,
  input wire logic        transmit_error_flag_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_ready_follows: assert property (in_ready_out == (!out_valid_out || out_ready_in))
    else $error("ready does not follow output space");
  a_out_hold: assert property (out_valid_out && !out_ready_in |=>
    out_valid_out && $stable({out_data_out, out_byte_count_out, out_eop_out})) else $error("output word not held");
  a_lane_bound: assert property (out_valid_out |-> out_byte_count_out inside {[1:4]} &&
    (out_first_byte_out + out_byte_count_out) <= 4) else $error("byte lanes out of range");
  a_fcs_forced: assert property (out_valid_out && !out_pad_enable_out |-> out_fcs_append_out)
    else $error("fcs dropped with padding off");
  a_status_pulse: assert property (status_valid_out |=> !status_valid_out)
    else $error("status longer than one cycle");
  a_flag_cause: assert property ($rose(transmit_error_flag_out) |-> status_valid_out && status_len_error_out)
    else $error("flag rose without mismatch");
  a_flag_set: assert property (status_valid_out && status_len_error_out |-> transmit_error_flag_out)
    else $error("mismatch did not set flag");
  a_flag_sticky: assert property (transmit_error_flag_out && !transmit_error_clear_in |=> transmit_error_flag_out)
    else $error("flag dropped without clear");
  a_flag_clears: assert property (transmit_error_flag_out && transmit_error_clear_in |=>
    !transmit_error_flag_out || (status_valid_out && status_len_error_out)) else $error("flag not cleared");
  a_tag_hold: assert property (!status_valid_out |-> $stable(status_tag_out))
    else $error("tag changed outside status");

  c_len_error: cover property (status_valid_out && status_len_error_out);
  c_len_good: cover property (status_valid_out && !status_len_error_out);
  c_stall: cover property (out_valid_out && !out_ready_in);
  c_eop: cover property (out_valid_out && out_eop_out);
endmodule : txcd_decoder_chk

// >>> sim/txcd_host_model.sv
// Host model feeding command and buffer words into the decoder
`timescale 1ns/1ps
module txcd_host_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Pacing from the bench
  input  wire logic        pause_in,
  // Word stream
  input  wire logic        in_ready_in,
  output logic             in_valid_out,
  output logic [31:0]      in_data_out
);
  logic [31:0] q[$];
  logic        taken;

  // A word is taken where valid and ready meet at a rising edge
  always @(posedge clk_in) taken <= in_valid_out && in_ready_in;
  // Idle data toggles so a stale word never looks valid
  always @(negedge clk_in) begin
    if (!rst_n_in) begin
      in_valid_out <= 1'b0;
      in_data_out  <= 32'h5A5A_A5A5;
    end else if (!in_valid_out || taken) begin
      if (q.size() != 0 && !pause_in) begin
        in_valid_out <= 1'b1;
        in_data_out  <= q.pop_front();
      end else begin
        in_valid_out <= 1'b0;
        in_data_out  <= ~in_data_out;
      end
    end
  end
endmodule : txcd_host_model

// >>> sim/txcd_decoder_tb.sv
// Self-checking bench for the transmit command word decoder
`timescale 1ns/1ps
bind txcd_decoder txcd_decoder_chk u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .in_ready_out(in_ready_out),
  .out_valid_out(out_valid_out), .out_ready_in(out_ready_in), .out_data_out(out_data_out),
  .out_first_byte_out(out_first_byte_out), .out_byte_count_out(out_byte_count_out), .out_eop_out(out_eop_out),
  .out_fcs_append_out(out_fcs_append_out), .out_pad_enable_out(out_pad_enable_out),
  .status_valid_out(status_valid_out), .status_tag_out(status_tag_out), .status_len_error_out(status_len_error_out),
  .transmit_error_clear_in(transmit_error_clear_in), .transmit_error_flag_out(transmit_error_flag_out));
module txcd_decoder_tb;
  logic        clk_in, rst_n_in, in_valid_in, in_ready_out, out_valid_out, out_ready_in, pause;
  logic [31:0] in_data_in, out_data_out;
  logic [1:0]  out_first_byte_out;
  logic [2:0]  out_byte_count_out;
  logic        out_sop_out, out_eop_out, out_fcs_append_out, out_pad_enable_out, exp_err;
  logic        status_valid_out, status_len_error_out, transmit_error_clear_in, transmit_error_flag_out;
  logic [15:0] status_tag_out;
  logic [40:0] exp_q[$];
  logic [16:0] stat_q[$];
  int          seed = 32'h567C34CC;
  int          miscompares = 0, total_checks = 0, cycles = 0;
  wire  [40:0] seen_word = {out_data_out, out_byte_count_out, out_first_byte_out, out_sop_out, out_eop_out,
                            out_fcs_append_out, out_pad_enable_out};

  txcd_decoder u_txcd_decoder (.clk_in(clk_in), .rst_n_in(rst_n_in), .in_valid_in(in_valid_in),
    .in_data_in(in_data_in), .in_ready_out(in_ready_out), .out_valid_out(out_valid_out),
    .out_ready_in(out_ready_in), .out_data_out(out_data_out), .out_first_byte_out(out_first_byte_out),
    .out_byte_count_out(out_byte_count_out), .out_sop_out(out_sop_out), .out_eop_out(out_eop_out),
    .out_fcs_append_out(out_fcs_append_out), .out_pad_enable_out(out_pad_enable_out),
    .status_valid_out(status_valid_out), .status_tag_out(status_tag_out),
    .status_len_error_out(status_len_error_out), .transmit_error_clear_in(transmit_error_clear_in),
    .transmit_error_flag_out(transmit_error_flag_out));
  txcd_host_model u_txcd_host_model (.clk_in(clk_in), .rst_n_in(rst_n_in), .pause_in(pause),
    .in_ready_in(in_ready_out), .in_valid_out(in_valid_in), .in_data_out(in_data_in));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      final_report();
    end
  end

  // Sink stalls and host pauses at random
  always @(negedge clk_in) begin
    out_ready_in <= ($random(seed) % 4) != 0;
    pause        <= ($random(seed) % 5) == 0;
  end

  always @(posedge clk_in) begin
    if (rst_n_in && out_valid_out && out_ready_in) begin
      if (exp_q.size() == 0) check("extra word", 1, 0);
      else check("data word", seen_word, exp_q.pop_front());
    end
    if (rst_n_in && status_valid_out) begin
      if (stat_q.size() == 0) check("extra status", 1, 0);
      else check("status", {status_tag_out, status_len_error_out}, stat_q.pop_front());
    end
  end

  // Queues one buffer and the data words it should yield
  task automatic add_buf(input bit first, last, input int size, ofs, aln, len, input logic [15:0] tag,
                         input bit nocrc, nopad);
    int          ab, total, lane, dw, rem, cnt, k;
    logic [31:0] w;
    ab    = (aln == 1) ? 16 : (aln == 2) ? 32 : 4;
    total = (ofs + size + ab - 1) / ab * ab / 4;
    lane  = ofs % 4;
    dw    = (size == 0) ? 0 : (lane + size + 3) / 4;
    rem   = size;
    u_txcd_host_model.q.push_back({6'h00, aln[1:0], 3'h0, ofs[4:0], 2'h0, first, last, 1'b0, size[10:0]});
    u_txcd_host_model.q.push_back({tag, 2'h0, nocrc, nopad, 1'b0, len[10:0]});
    for (int i = 0; i < total; i++) begin
      w = $random(seed);
      u_txcd_host_model.q.push_back(w);
      k = i - ofs / 4;
      if (k >= 0 && k < dw) begin
        cnt = (k == 0) ? 4 - lane : 4;
        if (cnt > rem) cnt = rem;
        rem -= cnt;
        exp_q.push_back({w, cnt[2:0], (k == 0) ? lane[1:0] : 2'h0, first && k == 0, last && k == dw - 1,
                         !nocrc || nopad, !nopad});
      end
    end
  endtask : add_buf

  task automatic send_packet(input int nseg, aln, input bit bad, nocrc, nopad, zero_last);
    int          size, sum, len;
    logic [15:0] tag;
    sum = 0;
    tag = $random(seed);
    for (int s = 0; s < nseg; s++) begin
      size = (s == 0) ? 1 + {$random(seed)} % 120 : 4 + {$random(seed)} % 120;
      if (zero_last && s > 0 && s == nseg - 1) size = 0;
      sum += size;
      len = (s == nseg - 1) ? sum + bad : {$random(seed)} % 2048;
      add_buf(s == 0, s == nseg - 1, size, {$random(seed)} % 32, aln, len, (s == 0) ? tag : 16'($random(seed)),
              nocrc, nopad);
    end
    stat_q.push_back({tag, bad});
    exp_err = exp_err | bad;
  endtask : send_packet

  task automatic drain;
    while (u_txcd_host_model.q.size() != 0 || in_valid_in || exp_q.size() != 0 || stat_q.size() != 0)
      @(negedge clk_in);
    repeat (2) @(negedge clk_in);
    check("error flag", transmit_error_flag_out, exp_err);
    transmit_error_clear_in = 1'b1;
    @(negedge clk_in);
    transmit_error_clear_in = 1'b0;
    @(negedge clk_in);
    check("flag cleared", transmit_error_flag_out, 0);
    exp_err = 1'b0;
  endtask : drain

  initial begin
    rst_n_in                = 1'b0;
    transmit_error_clear_in = 1'b0;
    exp_err                 = 1'b0;
    repeat (12) @(negedge clk_in);
    rst_n_in = 1'b1;
    for (int i = 0; i < 4; i++) begin
      send_packet(1, i, 1'b0, i[0], i[1], 1'b0);
      drain();
    end
    send_packet(3, 2, 1'b1, 1'b0, 1'b0, 1'b1);
    drain();
    for (int i = 0; i < 40; i++) begin
      send_packet(1 + {$random(seed)} % 3, {$random(seed)} % 4, ($random(seed) % 4) == 0, 1'($random(seed)),
                  1'($random(seed)), ($random(seed) % 3) == 0);
      if (i % 4 == 3) drain();
    end
    // Leave the flag set so that reset has something to clear
    send_packet(1, 0, 1'b1, 1'b0, 1'b0, 1'b0);
    while (exp_q.size() != 0 || stat_q.size() != 0)
      @(negedge clk_in);
    rst_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    check("flag in reset", transmit_error_flag_out, 0);
    check("tag in reset", status_tag_out, 0);
    check("handshake in reset", {out_valid_out, status_valid_out, in_ready_out}, 3'h1);
    exp_err  = 1'b0;
    rst_n_in = 1'b1;
    send_packet(2, 1, 1'b1, 1'b1, 1'b0, 1'b0);
    drain();
    final_report();
  end
endmodule : txcd_decoder_tb
